// File: hw/bsc_pkg.sv
package bsc_pkg;

  // ----------------------------------------
  // Widths and constants
  // ----------------------------------------
  localparam int unsigned SEG_W = 12;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned REG_IDX_W = 3;
  localparam logic [WORD_W-1:0] ONE_W = 16'h0001;
  localparam logic [WORD_W-1:0] ZERO_W = 16'h0000;
  localparam logic [31:0] ONE_L = 32'h0000_0001;
  localparam logic [WORD_W-1:0] SEQ_STEP = 16'h0001;
  localparam logic [WORD_W-1:0] SKIP_STEP = 16'h0002;
  localparam logic [WORD_W-1:0] CMP_LT_STEP = 16'h0001;
  localparam logic [WORD_W-1:0] CMP_EQ_STEP = 16'h0002;
  localparam logic [WORD_W-1:0] CMP_GT_STEP = 16'h0003;

  // ----------------------------------------
  // Relations and operations
  // ----------------------------------------
  typedef enum logic [2:0] {
    REL_EQ = 3'h0, REL_GE = 3'h1, REL_GT = 3'h2,
    REL_LE = 3'h3, REL_LT = 3'h4, REL_NE = 3'h5
  } bsc_rel_t;

  typedef enum logic [1:0] {
    STEP_1 = 2'h0, STEP_2 = 2'h1, STEP_4 = 2'h2
  } bsc_step_t;

  typedef enum logic [4:0] {
    OP_BR_ACC = 5'h00, OP_BR_CC = 5'h01, OP_BR_FLT = 5'h02,
    OP_BR_HALF = 5'h03, OP_BR_LONG = 5'h04, OP_BR_MAG = 5'h05,
    OP_BR_FULL = 5'h06, OP_BR_BIT_CLR = 5'h07, OP_BR_BIT_SET = 5'h08,
    OP_DEC_HALF = 5'h09, OP_INC_HALF = 5'h0a, OP_LT_REG = 5'h0b,
    OP_LT_CC = 5'h0c, OP_LT_HALF = 5'h0d, OP_LT_LONG = 5'h0e,
    OP_LT_ONE = 5'h0f, OP_LT_ZERO = 5'h10, OP_CMP_ACC_MEM = 5'h11,
    OP_CMP_ACC_ZERO = 5'h12, OP_CMP_LONG_MEM = 5'h13, OP_DEC_IDX = 5'h14,
    OP_INC_MEM = 5'h15, OP_INC_IDX = 5'h16, OP_SKIP_BIT_CLR = 5'h17,
    OP_SKIP_BIT_SET = 5'h18, OP_SKIP_POS = 5'h19, OP_SKIP_NEG = 5'h1a,
    OP_SKIP_FLT = 5'h1b, OP_SKIP_SW_CLR = 5'h1c, OP_SKIP_SW_SET = 5'h1d,
    OP_JUMP = 5'h1e
  } bsc_op_t;

  typedef enum logic [1:0] {
    MODE_S = 2'h0, MODE_R = 2'h1, MODE_V = 2'h2, MODE_I = 2'h3
  } bsc_mode_t;

  // Floating skip conditions
  typedef enum logic [2:0] {
    FSK_GT = 3'h0, FSK_LE = 3'h1, FSK_MI = 3'h2,
    FSK_NZ = 3'h3, FSK_PL = 3'h4, FSK_ZE = 3'h5
  } bsc_fsk_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [SEG_W-1:0] seg;
    logic [WORD_W-1:0] word;
  } bsc_pc_t;

  typedef struct packed {
    logic valid;
    bsc_op_t op;
    bsc_mode_t mode;
    bsc_rel_t rel;
    bsc_step_t step;
    bsc_fsk_t fsk;
    logic [3:0] bit_sel;
    logic [4:0] lbit_sel;
    logic [SEG_W-1:0] tgt_seg;
    logic [WORD_W-1:0] tgt_word;
  } bsc_instr_t;

  // Condition codes: lt = negative, eq = zero
  typedef struct packed {
    logic lt;
    logic eq;
    logic link;
  } bsc_cc_t;

  typedef struct packed {
    logic [WORD_W-1:0] acc;
    logic [31:0] lacc;
    logic flt_neg;
    logic flt_zero;
    logic [31:0] full_reg;
    logic [WORD_W-1:0] half_reg;
    logic [WORD_W-1:0] idx_reg;
    logic [WORD_W-1:0] mem_word;
    logic [31:0] mem_long;
    logic [3:0] sense_sw;
  } bsc_opnd_t;

  typedef struct packed {
    logic valid;
    bsc_pc_t pc;
    logic taken;
    logic wr_half;
    logic wr_full;
    logic wr_acc;
    logic wr_lacc;
    logic wr_idx;
    logic wr_mem;
    logic [31:0] wr_data;
  } bsc_res_t;

endpackage

// File: hw/bsc_unit.sv
// ----------------------------------------
// Functional notes
// [R1] Branch/skip targets stay in current segment
// [R2] Jumps may load another segment
// [R3] V-mode accumulator branches compare with zero
// [R4] Condition-code branches use stored codes only
// [R5] Floating branches test floating accumulator
// [R6] I-mode half-register branches compare zero
// [R7] V-mode long accumulator branches compare zero
// [R8] Magnitude branches use link plus codes
// [R9] I-mode full-register branches compare zero
// [R10] Register bit branches: clear or set
// [R11] Decrement half by 1/2/4, branch nonzero
// [R12] Increment half by 1/2/4, branch nonzero
// [R13] Register test loads one or zero
// [R14] Condition-code test loads one or zero
// [R15] Half/long tests load truth value
// [R16] Load true writes one, false zero
// [R17] Compare skips advance by outcome
// [R18] Counting skips step, write, skip zero
// [R19] Accumulator bit skips: clear or set
// [R20] Accumulator sign skips: positive, negative
// [R21] Floating skips per selected condition
// [R22] S/R sense-switch skips clear or set
// [R23] Taken skip adds one extra word
// ----------------------------------------
module bsc_unit (
  input wire logic sys_clk,
  input wire logic reset,
  input wire bsc_pkg::bsc_instr_t instr,
  input wire bsc_pkg::bsc_pc_t pc,
  input wire bsc_pkg::bsc_cc_t cc,
  input wire bsc_pkg::bsc_opnd_t opnd,
  output bsc_pkg::bsc_res_t res
);
  import bsc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic rel_hold(input bsc_rel_t r, input logic neg, input logic zero);
    logic h;
    h = 1'b0;
    unique case (r)
      REL_EQ: h = zero;
      REL_GE: h = !neg;
      REL_GT: h = !neg && !zero;
      REL_LE: h = neg || zero;
      REL_LT: h = neg;
      REL_NE: h = !zero;
      default: h = 1'b0;
    endcase
    return h;
  endfunction

  function automatic logic [WORD_W-1:0] step_val(input bsc_step_t s);
    logic [WORD_W-1:0] v;
    v = ONE_W;
    unique case (s)
      STEP_1: v = 16'h0001;
      STEP_2: v = 16'h0002;
      STEP_4: v = 16'h0004;
      default: v = ONE_W;
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    bsc_res_t res;
  } bsc_state_t;

  bsc_state_t st_q;
  bsc_state_t st_d;

  logic a_neg, a_zero, l_neg, l_zero, h_neg, h_zero, f_neg, f_zero;
  logic [WORD_W-1:0] half_dec, half_inc, idx_dec, idx_inc, mem_inc;
  logic [WORD_W-1:0] seq_pc;

  assign a_neg = opnd.acc[WORD_W-1];
  assign a_zero = (opnd.acc == ZERO_W);
  assign l_neg = opnd.lacc[31];
  assign l_zero = (opnd.lacc == 32'h0000_0000);
  assign h_neg = opnd.half_reg[WORD_W-1];
  assign h_zero = (opnd.half_reg == ZERO_W);
  assign f_neg = opnd.flt_neg;
  assign f_zero = opnd.flt_zero;
  assign half_dec = opnd.half_reg - step_val(instr.step); // [R11]
  assign half_inc = opnd.half_reg + step_val(instr.step); // [R12]
  assign idx_dec = opnd.idx_reg - ONE_W; // [R18]
  assign idx_inc = opnd.idx_reg + ONE_W; // [R18]
  assign mem_inc = opnd.mem_word + ONE_W; // [R18]
  assign seq_pc = pc.word + SEQ_STEP;

  // ----------------------------------------
  // Evaluation
  // ----------------------------------------
  always_comb begin
    logic br;
    logic sk;
    logic [WORD_W-1:0] adv;
    logic signed [32:0] cmp_l;
    logic signed [16:0] cmp_a;
    br = 1'b0;
    sk = 1'b0;
    adv = SEQ_STEP;
    cmp_l = 33'sh0;
    cmp_a = 17'sh0;
    st_d = st_q;
    st_d.res.valid = instr.valid;
    st_d.res.taken = 1'b0;
    st_d.res.wr_half = 1'b0;
    st_d.res.wr_full = 1'b0;
    st_d.res.wr_acc = 1'b0;
    st_d.res.wr_lacc = 1'b0;
    st_d.res.wr_idx = 1'b0;
    st_d.res.wr_mem = 1'b0;
    st_d.res.wr_data = 32'h0000_0000;
    st_d.res.pc.seg = pc.seg; // [R1]
    st_d.res.pc.word = seq_pc; // [R23]
    if (instr.valid) begin
      unique case (instr.op)
        OP_BR_ACC: br = (instr.mode == MODE_V) && rel_hold(instr.rel, a_neg, a_zero); // [R3]
        OP_BR_CC: br = rel_hold(instr.rel, cc.lt, cc.eq); // [R4]
        OP_BR_FLT: br = rel_hold(instr.rel, f_neg, f_zero); // [R5]
        OP_BR_HALF: br = (instr.mode == MODE_I) && rel_hold(instr.rel, h_neg, h_zero); // [R6]
        OP_BR_LONG: br = (instr.mode == MODE_V) && rel_hold(instr.rel, l_neg, l_zero); // [R7]
        // Unsigned magnitude: link is the carry, never negative
        OP_BR_MAG: br = rel_hold(instr.rel, 1'b0, cc.eq && !cc.link); // [R8]
        OP_BR_FULL: br = (instr.mode == MODE_I) &&
          rel_hold(instr.rel, opnd.full_reg[31], opnd.full_reg == 32'h0000_0000); // [R9]
        OP_BR_BIT_CLR: br = (instr.mode == MODE_I) && !opnd.full_reg[instr.lbit_sel]; // [R10]
        OP_BR_BIT_SET: br = (instr.mode == MODE_I) && opnd.full_reg[instr.lbit_sel]; // [R10]
        OP_DEC_HALF: begin
          st_d.res.wr_half = 1'b1; // [R11]
          st_d.res.wr_data = {16'h0000, half_dec};
          br = (half_dec != ZERO_W);
        end
        OP_INC_HALF: begin
          st_d.res.wr_half = 1'b1; // [R12]
          st_d.res.wr_data = {16'h0000, half_inc};
          br = (half_inc != ZERO_W);
        end
        OP_LT_REG: begin
          st_d.res.wr_full = 1'b1; // [R13]
          st_d.res.wr_data = rel_hold(instr.rel, opnd.full_reg[31],
            opnd.full_reg == 32'h0000_0000) ? ONE_L : 32'h0000_0000;
        end
        OP_LT_CC: begin
          st_d.res.wr_full = 1'b1; // [R14]
          st_d.res.wr_data = rel_hold(instr.rel, cc.lt, cc.eq) ? ONE_L : 32'h0000_0000;
        end
        OP_LT_HALF: begin
          st_d.res.wr_full = 1'b1; // [R15]
          st_d.res.wr_data = rel_hold(instr.rel, h_neg, h_zero) ? ONE_L : 32'h0000_0000;
        end
        OP_LT_LONG: begin
          st_d.res.wr_acc = 1'b1; // [R15]
          st_d.res.wr_data = rel_hold(instr.rel, l_neg, l_zero) ? ONE_L : 32'h0000_0000;
        end
        OP_LT_ONE: begin
          st_d.res.wr_full = 1'b1; // [R16]
          st_d.res.wr_data = ONE_L;
        end
        OP_LT_ZERO: begin
          st_d.res.wr_full = 1'b1; // [R16]
          st_d.res.wr_data = 32'h0000_0000;
        end
        // Compare skips: less, equal, greater advance 1, 2, 3 words
        OP_CMP_ACC_MEM, OP_CMP_ACC_ZERO: begin
          cmp_a = 17'(signed'(opnd.acc)) -
            ((instr.op == OP_CMP_ACC_ZERO) ? 17'sh0 : 17'(signed'(opnd.mem_word)));
          adv = (cmp_a < 0) ? CMP_LT_STEP : (cmp_a == 0) ? CMP_EQ_STEP : CMP_GT_STEP; // [R17]
        end
        OP_CMP_LONG_MEM: begin
          cmp_l = 33'(signed'(opnd.lacc)) - 33'(signed'(opnd.mem_long));
          adv = (cmp_l < 0) ? CMP_LT_STEP : (cmp_l == 0) ? CMP_EQ_STEP : CMP_GT_STEP; // [R17]
        end
        OP_DEC_IDX: begin
          st_d.res.wr_idx = 1'b1; // [R18]
          st_d.res.wr_data = {16'h0000, idx_dec};
          sk = (idx_dec == ZERO_W);
        end
        OP_INC_IDX: begin
          st_d.res.wr_idx = 1'b1; // [R18]
          st_d.res.wr_data = {16'h0000, idx_inc};
          sk = (idx_inc == ZERO_W);
        end
        OP_INC_MEM: begin
          st_d.res.wr_mem = 1'b1; // [R18]
          st_d.res.wr_data = {16'h0000, mem_inc};
          sk = (mem_inc == ZERO_W);
        end
        OP_SKIP_BIT_CLR: sk = !opnd.acc[instr.bit_sel]; // [R19]
        OP_SKIP_BIT_SET: sk = opnd.acc[instr.bit_sel]; // [R19]
        OP_SKIP_POS: sk = !a_neg && !a_zero; // [R20]
        OP_SKIP_NEG: sk = a_neg; // [R20]
        OP_SKIP_FLT: begin
          unique case (instr.fsk) // [R21]
            FSK_GT, FSK_PL: sk = !f_neg && !f_zero;
            FSK_LE: sk = f_neg || f_zero;
            FSK_MI: sk = f_neg;
            FSK_NZ: sk = !f_zero;
            FSK_ZE: sk = f_zero;
            default: sk = 1'b0;
          endcase
        end
        OP_SKIP_SW_CLR: sk = (instr.mode inside {MODE_S, MODE_R}) &&
          !opnd.sense_sw[instr.bit_sel[1:0]]; // [R22]
        OP_SKIP_SW_SET: sk = (instr.mode inside {MODE_S, MODE_R}) &&
          opnd.sense_sw[instr.bit_sel[1:0]]; // [R22]
        OP_JUMP: begin
          st_d.res.taken = 1'b1;
          st_d.res.pc.seg = instr.tgt_seg; // [R2]
          st_d.res.pc.word = instr.tgt_word;
        end
        default: ;
      endcase
      if (br) begin
        st_d.res.taken = 1'b1;
        st_d.res.pc.seg = pc.seg; // [R1]
        st_d.res.pc.word = instr.tgt_word;
      end else if (sk) begin
        st_d.res.taken = 1'b1;
        st_d.res.pc.word = pc.word + SKIP_STEP; // [R23]
      end else if (adv != SEQ_STEP) begin
        st_d.res.pc.word = pc.word + adv; // [R17]
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign res = st_q.res;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_seg_kept: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
    instr.valid && instr.op != OP_JUMP |=> res.pc.seg == $past(pc.seg))
    else $error("segment changed by branch or skip");
  a_jump_seg: assert property (@(posedge sys_clk) disable iff (reset) // [R2]
    instr.valid && instr.op == OP_JUMP |=> res.pc.seg == $past(instr.tgt_seg))
    else $error("jump segment not loaded");
  a_acc_beq: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
    instr.valid && instr.op == OP_BR_ACC && instr.mode == MODE_V && instr.rel == REL_EQ
    |=> res.taken == ($past(opnd.acc) == ZERO_W))
    else $error("accumulator equal branch wrong");
  a_cc_branch: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
    instr.valid && instr.op == OP_BR_CC && instr.rel == REL_LT |=> res.taken == $past(cc.lt))
    else $error("condition code branch wrong");
  a_dec_write: assert property (@(posedge sys_clk) disable iff (reset) // [R11]
    instr.valid && instr.op == OP_DEC_HALF && instr.step == STEP_4
    |=> res.wr_half && res.wr_data[15:0] == $past(opnd.half_reg) - 16'h0004)
    else $error("half decrement wrong");
  a_inc_taken: assert property (@(posedge sys_clk) disable iff (reset) // [R12]
    instr.valid && instr.op == OP_INC_HALF |=> res.taken == (res.wr_data[15:0] != ZERO_W))
    else $error("half increment branch wrong");
  a_load_true: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
    instr.valid && instr.op == OP_LT_ONE |=> res.wr_full && res.wr_data == ONE_L)
    else $error("load true wrong");
  a_skip_step: assert property (@(posedge sys_clk) disable iff (reset) // [R23]
    instr.valid && instr.op == OP_SKIP_NEG
    |=> res.pc.word == $past(pc.word) + ($past(opnd.acc[15]) ? SKIP_STEP : SEQ_STEP))
    else $error("skip advance wrong");
  a_idx_skip: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
    instr.valid && instr.op == OP_INC_IDX && opnd.idx_reg == 16'hffff
    |=> res.taken && res.wr_idx && res.wr_data == 32'h0000_0000)
    else $error("index increment skip wrong");
  a_acc_gate: assert property (@(posedge sys_clk) disable iff (reset) // [R3]
    instr.valid && instr.op == OP_BR_ACC && instr.mode != MODE_V
    |=> !res.taken)
    else $error("accumulator branch taken outside its mode");
  a_cc_ne: assert property (@(posedge sys_clk) disable iff (reset) // [R4]
    instr.valid && instr.op == OP_BR_CC && instr.rel == REL_NE
    |=> res.taken == !$past(cc.eq))
    else $error("condition code not-equal branch wrong");
  a_branch_target: assert property (@(posedge sys_clk) disable iff (reset) // [R1]
    instr.valid && instr.op == OP_BR_FLT
    |=> res.pc.word == (res.taken ? $past(instr.tgt_word) : $past(pc.word) + SEQ_STEP))
    else $error("floating branch target wrong");
  a_half_gt: assert property (@(posedge sys_clk) disable iff (reset) // [R6]
    instr.valid && instr.op == OP_BR_HALF && instr.mode == MODE_I && instr.rel == REL_GT
    |=> res.taken == (!$past(opnd.half_reg[WORD_W-1]) && $past(opnd.half_reg) != ZERO_W))
    else $error("half register greater branch wrong");
  a_long_lt: assert property (@(posedge sys_clk) disable iff (reset) // [R7]
    instr.valid && instr.op == OP_BR_LONG && instr.mode == MODE_V && instr.rel == REL_LT
    |=> res.taken == $past(opnd.lacc[31]))
    else $error("long accumulator less branch wrong");
  a_mag_eq: assert property (@(posedge sys_clk) disable iff (reset) // [R8]
    instr.valid && instr.op == OP_BR_MAG && instr.rel == REL_EQ
    |=> res.taken == ($past(cc.eq) && !$past(cc.link)))
    else $error("magnitude equal branch wrong");
  a_full_ge: assert property (@(posedge sys_clk) disable iff (reset) // [R9]
    instr.valid && instr.op == OP_BR_FULL && instr.mode == MODE_I && instr.rel == REL_GE
    |=> res.taken == !$past(opnd.full_reg[31]))
    else $error("full register branch wrong");
  a_bit_set: assert property (@(posedge sys_clk) disable iff (reset) // [R10]
    instr.valid && instr.op == OP_BR_BIT_SET && instr.mode == MODE_I
    |=> res.taken == $past(opnd.full_reg[instr.lbit_sel]))
    else $error("register bit set branch wrong");
  a_lt_reg: assert property (@(posedge sys_clk) disable iff (reset) // [R13]
    instr.valid && instr.op == OP_LT_REG && instr.rel == REL_EQ
    |=> res.wr_full && res.wr_data == {31'h0, $past(opnd.full_reg) == 32'h0000_0000})
    else $error("register logic test wrong");
  a_lt_cc: assert property (@(posedge sys_clk) disable iff (reset) // [R14]
    instr.valid && instr.op == OP_LT_CC && instr.rel == REL_LT
    |=> res.wr_full && res.wr_data == {31'h0, $past(cc.lt)})
    else $error("condition code logic test wrong");
  a_lt_half: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
    instr.valid && instr.op == OP_LT_HALF && instr.rel == REL_LE
    |=> res.wr_full && res.wr_data[0] == ($past(opnd.half_reg[WORD_W-1]) || $past(a_zero)))
    else $error("half register logic test wrong");
  a_lt_long: assert property (@(posedge sys_clk) disable iff (reset) // [R15]
    instr.valid && instr.op == OP_LT_LONG && instr.rel == REL_NE
    |=> res.wr_acc && res.wr_data == {31'h0, $past(opnd.lacc) != 32'h0000_0000})
    else $error("long accumulator logic test wrong");
  a_load_false: assert property (@(posedge sys_clk) disable iff (reset) // [R16]
    instr.valid && instr.op == OP_LT_ZERO
    |=> res.wr_full && res.wr_data == 32'h0000_0000)
    else $error("load false wrong");
  a_cmp_equal: assert property (@(posedge sys_clk) disable iff (reset) // [R17]
    instr.valid && instr.op == OP_CMP_ACC_ZERO && opnd.acc == ZERO_W
    |=> res.pc.word == $past(pc.word) + CMP_EQ_STEP)
    else $error("compare zero equal advance wrong");
  a_idx_dec_skip: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
    instr.valid && instr.op == OP_DEC_IDX && opnd.idx_reg == ONE_W
    |=> res.taken && res.wr_idx && res.wr_data == 32'h0000_0000)
    else $error("index decrement skip wrong");
  a_mem_inc: assert property (@(posedge sys_clk) disable iff (reset) // [R18]
    instr.valid && instr.op == OP_INC_MEM
    |=> res.wr_mem && res.wr_data[WORD_W-1:0] == $past(opnd.mem_word) + ONE_W)
    else $error("memory increment wrong");
  a_bit_clear: assert property (@(posedge sys_clk) disable iff (reset) // [R19]
    instr.valid && instr.op == OP_SKIP_BIT_CLR
    |=> res.taken == !$past(opnd.acc[instr.bit_sel]))
    else $error("accumulator bit clear skip wrong");
  a_acc_pos: assert property (@(posedge sys_clk) disable iff (reset) // [R20]
    instr.valid && instr.op == OP_SKIP_POS
    |=> res.taken == (!$past(opnd.acc[WORD_W-1]) && $past(opnd.acc) != ZERO_W))
    else $error("accumulator positive skip wrong");
  a_flt_nz: assert property (@(posedge sys_clk) disable iff (reset) // [R21]
    instr.valid && instr.op == OP_SKIP_FLT && instr.fsk == FSK_NZ
    |=> res.taken == !$past(opnd.flt_zero))
    else $error("floating nonzero skip wrong");
  a_switch_gate: assert property (@(posedge sys_clk) disable iff (reset) // [R22]
    instr.valid && instr.op inside {OP_SKIP_SW_CLR, OP_SKIP_SW_SET} &&
    instr.mode inside {MODE_V, MODE_I} |=> !res.taken)
    else $error("sense switch skip taken outside its modes");
  a_switch_set: assert property (@(posedge sys_clk) disable iff (reset) // [R22]
    instr.valid && instr.op == OP_SKIP_SW_SET && instr.mode == MODE_S
    |=> res.taken == $past(opnd.sense_sw[instr.bit_sel[1:0]]))
    else $error("sense switch set skip wrong");
endmodule

// File: tb/test_branch_skip_condition_unit.sv
module test_branch_skip_condition_unit;
  timeunit 1ns;
  timeprecision 1ps;
  import bsc_pkg::*;

  typedef struct packed {
    bsc_pc_t pc;
    logic chk_taken;
    logic taken;
    logic [5:0] wr;
    logic [31:0] data;
  } bsc_exp_t;

  logic sys_clk;
  logic reset;
  bsc_instr_t instr;
  bsc_pc_t pc;
  bsc_cc_t cc;
  bsc_opnd_t opnd;
  bsc_res_t res;
  bsc_exp_t exp_q[$];
  int n_mismatch;
  int n_compared;
  int cycles;

  bsc_unit i_bsc_unit (.sys_clk(sys_clk), .reset(reset), .instr(instr), .pc(pc), .cc(cc),
    .opnd(opnd), .res(res));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic rel_ok(bsc_rel_t r, logic n, logic z);
    case (r)
      REL_EQ: return z;
      REL_GE: return !n;
      REL_GT: return !n && !z;
      REL_LE: return n || z;
      REL_LT: return n;
      default: return !z;
    endcase
  endfunction

  task automatic check(string what, logic [31:0] exp_v, logic [31:0] seen);
    n_compared++;
    if (seen !== exp_v) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp_v, seen);
    end
  endtask

  task automatic conclude();
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Driver with reference model
  // ----------------------------------------
  task automatic issue(input bsc_op_t op, input logic odd);
    bsc_instr_t i;
    bsc_opnd_t o;
    bsc_cc_t c;
    bsc_pc_t p;
    bsc_exp_t e;
    bsc_mode_t md;
    logic [31:0] v, a, m;
    logic [15:0] st, nw;
    logic b, hit, gated;
    md = MODE_V;
    gated = 1'b1;
    case (op)
      OP_BR_HALF, OP_BR_FULL, OP_BR_BIT_CLR, OP_BR_BIT_SET: md = MODE_I;
      OP_SKIP_SW_CLR, OP_SKIP_SW_SET: md = bsc_mode_t'($urandom_range(1));
      OP_BR_ACC, OP_BR_LONG: md = MODE_V;
      OP_DEC_HALF, OP_INC_HALF, OP_LT_HALF: begin
        md = MODE_I;
        gated = 1'b0;
      end
      default: gated = 1'b0;
    endcase
    // Wrong modes only where refusal is defined
    if (odd && gated) md = bsc_mode_t'($urandom_range(3));
    i.valid = 1'b1;
    i.op = op;
    i.mode = md;
    i.rel = bsc_rel_t'($urandom_range(5));
    i.step = bsc_step_t'($urandom_range(2));
    i.fsk = bsc_fsk_t'($urandom_range(5));
    i.bit_sel = 4'($urandom);
    i.lbit_sel = 5'($urandom);
    i.tgt_seg = 12'($urandom);
    i.tgt_word = 16'($urandom);
    p.seg = 12'($urandom);
    p.word = ($urandom_range(3) == 0) ? 16'hffff : 16'($urandom);
    // Accumulator, long, full, half, floating and code operands share one sign class so any register reading agrees
    case ($urandom_range(2))
      0: v = 32'h0;
      1: v = {17'h1ffff, 15'($urandom)};
      default: v = {17'h0, 15'($urandom_range(32767, 1))};
    endcase
    b = 1'($urandom);
    o.acc = v[15:0];
    o.lacc = v;
    o.full_reg = v;
    o.half_reg = v[15:0];
    o.flt_neg = v[31];
    o.flt_zero = (v == 32'h0);
    o.idx_reg = 16'hffff + 16'($urandom_range(2));
    o.mem_word = 16'hffff + 16'($urandom_range(2));
    o.mem_long = {{16{o.mem_word[15]}}, o.mem_word};
    o.sense_sw = {4{b}};
    c.lt = v[31];
    c.eq = (v == 32'h0);
    c.link = 1'($urandom);
    // Uniform bit patterns keep bit numbering out of the expectation
    if (op inside {OP_BR_BIT_CLR, OP_BR_BIT_SET, OP_SKIP_BIT_CLR, OP_SKIP_BIT_SET}) begin
      o.full_reg = {32{b}};
      o.acc = {16{b}};
    end
    if (op == OP_DEC_HALF) o.half_reg = 16'($urandom_range(5));
    if (op == OP_INC_HALF) o.half_reg = 16'hfffb + 16'($urandom_range(5));
    st = (i.step == STEP_1) ? 16'h1 : (i.step == STEP_2) ? 16'h2 : 16'h4;
    e.pc = p;
    e.pc.word = p.word + SEQ_STEP;
    e.chk_taken = 1'b1;
    e.wr = 6'h00;
    e.data = 32'h0;
    hit = 1'b0;
    case (op)
      OP_BR_ACC: hit = md == MODE_V && rel_ok(i.rel, o.acc[15], o.acc == 16'h0);
      OP_BR_CC: hit = rel_ok(i.rel, c.lt, c.eq);
      OP_BR_FLT: hit = rel_ok(i.rel, o.flt_neg, o.flt_zero);
      OP_BR_HALF: hit = md == MODE_I && rel_ok(i.rel, o.half_reg[15], o.half_reg == 0);
      OP_BR_LONG: hit = md == MODE_V && rel_ok(i.rel, o.lacc[31], o.lacc == 0);
      OP_BR_MAG: hit = rel_ok(i.rel, 1'b0, c.eq && !c.link);
      OP_BR_FULL: hit = md == MODE_I && rel_ok(i.rel, o.full_reg[31], o.full_reg == 0);
      OP_BR_BIT_CLR: hit = md == MODE_I && !b;
      OP_BR_BIT_SET: hit = md == MODE_I && b;
      OP_DEC_HALF, OP_INC_HALF: begin
        nw = (op == OP_DEC_HALF) ? o.half_reg - st : o.half_reg + st;
        hit = nw != 16'h0;
        e.wr = 6'h20;
        e.data = {16'h0, nw};
      end
      OP_LT_REG, OP_LT_CC, OP_LT_HALF, OP_LT_LONG, OP_LT_ONE, OP_LT_ZERO: begin
        e.chk_taken = 1'b0;
        e.wr = (op == OP_LT_LONG) ? 6'h08 : 6'h10;
        e.data[0] = rel_ok(i.rel, v[31], v == 32'h0);
        if (op == OP_LT_ONE) e.data = ONE_L;
        if (op == OP_LT_ZERO) e.data = 32'h0;
      end
      OP_CMP_ACC_MEM, OP_CMP_ACC_ZERO, OP_CMP_LONG_MEM: begin
        a = (op == OP_CMP_LONG_MEM) ? o.lacc : {{16{o.acc[15]}}, o.acc};
        m = (op == OP_CMP_ACC_ZERO) ? 32'h0 : o.mem_long;
        e.chk_taken = 1'b0;
        e.pc.word = p.word + (($signed(a) < $signed(m)) ? CMP_LT_STEP :
          (a == m) ? CMP_EQ_STEP : CMP_GT_STEP);
      end
      OP_DEC_IDX, OP_INC_IDX, OP_INC_MEM: begin
        nw = (op == OP_DEC_IDX) ? o.idx_reg - 16'h1 : (op == OP_INC_IDX) ? o.idx_reg + 16'h1 :
          o.mem_word + 16'h1;
        hit = nw == 16'h0;
        e.wr = (op == OP_INC_MEM) ? 6'h01 : 6'h02;
        e.data = {16'h0, nw};
      end
      OP_SKIP_BIT_CLR: hit = !b;
      OP_SKIP_BIT_SET: hit = b;
      OP_SKIP_POS: hit = !o.acc[15] && o.acc != 16'h0;
      OP_SKIP_NEG: hit = o.acc[15];
      OP_SKIP_FLT: begin
        case (i.fsk)
          FSK_GT, FSK_PL: hit = !o.flt_neg && !o.flt_zero;
          FSK_LE: hit = o.flt_neg || o.flt_zero;
          FSK_MI: hit = o.flt_neg;
          FSK_NZ: hit = !o.flt_zero;
          default: hit = o.flt_zero;
        endcase
      end
      OP_SKIP_SW_CLR: hit = md inside {MODE_S, MODE_R} && !b;
      OP_SKIP_SW_SET: hit = md inside {MODE_S, MODE_R} && b;
      default: begin
        e.chk_taken = 1'b0;
        e.pc = {i.tgt_seg, i.tgt_word};
      end
    endcase
    // Taken branches and skips keep the current segment
    if (hit && op <= OP_INC_HALF) e.pc.word = i.tgt_word;
    else if (hit) e.pc.word = p.word + SKIP_STEP;
    e.taken = hit;
    @(posedge sys_clk);
    instr <= i;
    pc <= p;
    cc <= c;
    opnd <= o;
    exp_q.push_back(e);
  endtask

  // ----------------------------------------
  // Result monitor
  // ----------------------------------------
  always @(negedge sys_clk) begin
    bsc_exp_t e;
    if (!reset && res.valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("res.valid", 32'h0, 32'h1);
      end else begin
        e = exp_q.pop_front();
        check("pc", {4'h0, e.pc}, {4'h0, res.pc});
        if (e.chk_taken) check("taken", {31'h0, e.taken}, {31'h0, res.taken});
        check("strobes", {26'h0, e.wr}, {26'h0, res.wr_half, res.wr_full, res.wr_acc,
          res.wr_lacc, res.wr_idx, res.wr_mem});
        if (e.wr != 6'h00) check("wr_data", e.data, res.wr_data);
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      $display("Error timeout expected 0 seen %0d", exp_q.size());
      conclude();
    end
  end

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    cycles = 0;
    reset = 1'b1;
    instr = '0;
    pc = '0;
    cc = '0;
    opnd = '0;
    void'($urandom(32'hb413e4c2));
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int k = 0; k <= 30; k++) issue(bsc_op_t'(k), 1'b0);
    repeat (900) begin
      if ($urandom_range(4) == 0) begin
        @(posedge sys_clk);
        instr.valid <= 1'b0;
      end
      issue(bsc_op_t'($urandom_range(30)), $urandom_range(4) == 0);
    end
    @(posedge sys_clk);
    instr.valid <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("pending", 32'h0, 32'(exp_q.size()));
    conclude();
  end
endmodule
